/* File: shared/ptcp_pkg.sv */
// Shared constants, types and register map of the periodic timer
package ptcp_pkg;

  localparam int unsigned CNT_W     = 10;
  localparam logic [9:0]  CNT_ZERO  = 10'h000;
  localparam logic [9:0]  CNT_ONE   = 10'h001;
  localparam logic [9:0]  CNT_MAX   = 10'h3ff;
  localparam logic [9:0]  CMP_RST   = 10'h000;

  // Register byte addresses on the bus, one 32-bit word each
  localparam int unsigned ADR_W        = 8;
  localparam logic [7:0]  ADR_CTRL0    = 8'h00;
  localparam logic [7:0]  ADR_CTRL1    = 8'h04;
  localparam logic [7:0]  ADR_CNT_LO   = 8'h08;
  localparam logic [7:0]  ADR_CNT_HI   = 8'h0c;
  localparam logic [7:0]  ADR_CMPA_LO  = 8'h10;
  localparam logic [7:0]  ADR_CMPA_HI  = 8'h14;
  localparam logic [7:0]  ADR_PER_LO   = 8'h18;
  localparam logic [7:0]  ADR_PER_HI   = 8'h1c;
  localparam logic [7:0]  ADR_FLAGS    = 8'h20;

  localparam logic [7:0]  CTRL0_RST    = 8'h00;
  localparam logic [7:0]  CTRL1_RST    = 8'h00;
  localparam int unsigned FLAG_A_BIT   = 0;
  localparam int unsigned FLAG_P_BIT   = 1;
  localparam int unsigned HI_BITS      = 2;
  localparam logic [5:0]  HI_PAD       = 6'h00;
  localparam logic [23:0] WORD_PAD     = 24'h000000;

  // Prescaler for the divided counter clocks
  localparam int unsigned PRE_W        = 6;
  localparam logic [5:0]  PRE_RST      = 6'h00;
  localparam logic [5:0]  PRE_DIV4     = 6'h03;
  localparam logic [5:0]  PRE_DIV16    = 6'h0f;
  localparam logic [5:0]  PRE_DIV64    = 6'h3f;

  typedef enum logic [1:0] {
    PTCP_MODE_CMP = 2'b00,
    PTCP_MODE_CAP = 2'b01,
    PTCP_MODE_PWM = 2'b10,
    PTCP_MODE_TMR = 2'b11
  } ptcp_mode_e;

  // Compare mode: none/low/high/toggle; PWM: inactive/active/pwm/single
  typedef enum logic [1:0] {
    PTCP_IO_00 = 2'b00,
    PTCP_IO_01 = 2'b01,
    PTCP_IO_10 = 2'b10,
    PTCP_IO_11 = 2'b11
  } ptcp_io_e;

  typedef enum logic [2:0] {
    PTCP_CK_SYS4  = 3'b000,
    PTCP_CK_SYS   = 3'b001,
    PTCP_CK_HI16  = 3'b010,
    PTCP_CK_HI64  = 3'b011,
    PTCP_CK_SUB   = 3'b100,
    PTCP_CK_SUB2  = 3'b101,
    PTCP_CK_TRISE = 3'b110,
    PTCP_CK_TFALL = 3'b111
  } ptcp_clksrc_e;

  typedef struct packed {
    logic         pause;
    ptcp_clksrc_e clk_src;
    logic         enable;
    logic [2:0]   pad;
  } ptcp_ctrl0_s;

  typedef struct packed {
    ptcp_mode_e mode;
    ptcp_io_e   io;
    logic       init_level;
    logic       invert;
    logic       trig_src;
    logic       clear_src;
  } ptcp_ctrl1_s;

endpackage

/* File: rtl/ptcp_cmp.sv */
// Equality comparator of the counter against one compare value
`timescale 1ns/1ps
module ptcp_cmp
  import ptcp_pkg::*;
#(
  parameter int unsigned W = CNT_W
) (
  input  wire logic [W-1:0] count,
  input  wire logic [W-1:0] value,
  output logic              hit,
  output logic              zero
);

  assign hit  = (count == value);
  assign zero = (value == '0);

endmodule // ptcp_cmp

/* File: rtl/ptcp_clk_sel.sv */
// Counter clock enable selection and system clock prescaler
`timescale 1ns/1ps
module ptcp_clk_sel
  import ptcp_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire ptcp_clksrc_e clk_src,
  input  wire logic         sub_tick,
  input  wire logic         trig_rise,
  input  wire logic         trig_fall,
  output logic              tick
);

  logic [PRE_W-1:0] pre;

  // Free running so divided ticks keep a fixed phase
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pre <= PRE_RST;
    end else begin
      pre <= pre + 6'h01;
    end
  end

  // High clock taken as the system clock; one clock domain only
  always_comb begin
    unique case (clk_src)
      PTCP_CK_SYS4:  tick = ((pre & PRE_DIV4) == PRE_DIV4);
      PTCP_CK_SYS:   tick = 1'b1;
      PTCP_CK_HI16:  tick = ((pre & PRE_DIV16) == PRE_DIV16);
      PTCP_CK_HI64:  tick = (pre == PRE_DIV64);
      PTCP_CK_SUB:   tick = sub_tick;
      PTCP_CK_SUB2:  tick = sub_tick;
      PTCP_CK_TRISE: tick = trig_rise;
      PTCP_CK_TFALL: tick = trig_fall;
    endcase
  end

endmodule // ptcp_clk_sel

/* File: rtl/ptcp_timer.sv */
// Periodic timer with compare, PWM and single pulse output
//
// Summary of operation
// - Counter readable as low byte, two high bits
// - Compare A value read/write, ten bits
// - Period value read/write, ten bits
// - Compare mode: clear on P or overflow
// - Clear on A: only A flag raised
// - A zero: overflow at maximum, no A flag
// - Compare pin changes only on A match and on enable rise
// - Action field: none, low, high, toggle
// - Enable rising edge restores initial pin level
// - Timer mode counts like compare, pin unused
// - PWM: P sets period, A sets duty
// - PWM period P clocks, zero gives 1024
// - A at or above period: full duty
// - PWM raises both match flags
// - PWM polarity and forced pin levels
// - Forced levels keep PWM counting and flags
// - Invert bit inverts the output pin
// - Trigger edge sets enable, starts pulse
// - A match or software clear ends pulse
// - Single pulse counter zeroed only on start
// - Enable rise zeroes counter, fall holds it
// - Clock source field picks counter clock
// - Pause bit freezes counter, resumes later
// - Initial level bit sets pin before match
`timescale 1ns/1ps
module ptcp_timer
  import ptcp_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             sub_clk_tick,
  input  wire logic             trigger_pin,
  output logic                  timer_pin,
  output logic                  timer_pin_oe,
  output logic                  match_a_flag,
  output logic                  match_p_flag
);

  ptcp_ctrl0_s       ctrl0;
  ptcp_ctrl1_s       ctrl1;
  logic [CNT_W-1:0]  count;
  logic [CNT_W-1:0]  cmp_a;
  logic [CNT_W-1:0]  period;
  logic              enable_q;
  logic              trigger_q;
  logic              cmp_level;

  logic              bus_req;
  logic              bus_wr;
  logic [7:0]        wr_byte;
  logic [7:0]        rd_byte;
  logic              tick;
  logic              run;
  logic              step;
  logic              enable_rise;
  logic              trig_rise;
  logic              trig_fall;
  logic              single_mode;
  logic              pwm_mode;
  logic              a_hit;
  logic              a_zero;
  logic              p_hit;
  logic              p_zero;
  logic              end_hit;
  logic [CNT_W-1:0]  period_last;
  logic              clear_now;
  logic              ev_a;
  logic              ev_p;
  logic              pwm_full;
  logic              pwm_on;
  logic              pwm_active;
  logic              next_pin;
  logic              next_oe;

  // Bus access decode

  // Answer comes one cycle after the request and drops right after
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
  assign wr_byte = wb_dat_i[7:0];

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always_comb begin
    unique case (wb_adr_i)
      ADR_CTRL0:   rd_byte = ctrl0;
      ADR_CTRL1:   rd_byte = ctrl1;
      ADR_CNT_LO:  rd_byte = count[7:0];
      ADR_CNT_HI:  rd_byte = {HI_PAD, count[CNT_W-1:8]};
      ADR_CMPA_LO: rd_byte = cmp_a[7:0];
      ADR_CMPA_HI: rd_byte = {HI_PAD, cmp_a[CNT_W-1:8]};
      ADR_PER_LO:  rd_byte = period[7:0];
      ADR_PER_HI:  rd_byte = {HI_PAD, period[CNT_W-1:8]};
      ADR_FLAGS:   rd_byte = {HI_PAD, match_p_flag, match_a_flag};
      default:     rd_byte = 8'h00;
    endcase
  end

  // Unmapped addresses still answer, reading as zero
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wb_dat_o <= 32'h00000000;
    end else if (bus_req) begin
      wb_dat_o <= {WORD_PAD, rd_byte};
    end
  end

  // Compare values

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cmp_a <= CMP_RST;
    end else if (bus_wr && wb_adr_i == ADR_CMPA_LO) begin
      cmp_a[7:0] <= wr_byte;
    end else if (bus_wr && wb_adr_i == ADR_CMPA_HI) begin
      cmp_a[CNT_W-1:8] <= wr_byte[HI_BITS-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      period <= CMP_RST;
    end else if (bus_wr && wb_adr_i == ADR_PER_LO) begin
      period[7:0] <= wr_byte;
    end else if (bus_wr && wb_adr_i == ADR_PER_HI) begin
      period[CNT_W-1:8] <= wr_byte[HI_BITS-1:0];
    end
  end

  // Control one; mode and action are meant to change only while off
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl1 <= CTRL1_RST;
    end else if (bus_wr && wb_adr_i == ADR_CTRL1) begin
      ctrl1 <= wr_byte;
    end
  end

  // Control zero; hardware moves the enable bit in single pulse mode
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl0 <= CTRL0_RST;
    end else begin
      if (bus_wr && wb_adr_i == ADR_CTRL0) begin
        ctrl0.pause   <= wr_byte[7];
        ctrl0.clk_src <= ptcp_clksrc_e'(wr_byte[6:4]);
        ctrl0.enable  <= wr_byte[3];
      end
      if (single_mode && trig_rise) begin
        ctrl0.enable <= 1'b1;
      end
      if (single_mode && step && a_hit) begin
        ctrl0.enable <= 1'b0;
      end
    end
  end

  // Counter clock

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      trigger_q <= 1'b0;
      enable_q  <= 1'b0;
    end else begin
      trigger_q <= trigger_pin;
      enable_q  <= ctrl0.enable;
    end
  end

  assign trig_rise   = trigger_pin & ~trigger_q;
  assign trig_fall   = ~trigger_pin & trigger_q;
  assign enable_rise = ctrl0.enable & ~enable_q;

  ptcp_clk_sel u_clk_sel (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .clk_src   (ctrl0.clk_src),
    .sub_tick  (sub_clk_tick),
    .trig_rise (trig_rise),
    .trig_fall (trig_fall),
    .tick      (tick)
  );

  assign run  = ctrl0.enable & ~ctrl0.pause;
  // No step on the zeroing edge, so a stale count never matches
  assign step = tick & run & ~enable_rise;

  // Comparators

  assign pwm_mode    = (ctrl1.mode == PTCP_MODE_PWM) &&
                       (ctrl1.io != PTCP_IO_11);
  assign single_mode = (ctrl1.mode == PTCP_MODE_PWM) &&
                       (ctrl1.io == PTCP_IO_11);

  ptcp_cmp #(.W(CNT_W)) u_cmp_a (
    .count (count),
    .value (cmp_a),
    .hit   (a_hit),
    .zero  (a_zero)
  );

  ptcp_cmp #(.W(CNT_W)) u_cmp_p (
    .count (count),
    .value (period),
    .hit   (p_hit),
    .zero  (p_zero)
  );

  assign period_last = period - CNT_ONE;

  // A period of zero wraps here, giving the full 1024 count period
  ptcp_cmp #(.W(CNT_W)) u_cmp_end (
    .count (count),
    .value (period_last),
    .hit   (end_hit),
    .zero  ()
  );

  // Clear and flag events, judged on the value the counter holds now
  always_comb begin
    clear_now = 1'b0;
    ev_a      = 1'b0;
    ev_p      = 1'b0;
    if (single_mode) begin
      ev_a = a_hit;
    end else if (pwm_mode) begin
      clear_now = end_hit;
      ev_a = a_hit;
      ev_p = end_hit;
    end else if (ctrl1.clear_src) begin
      clear_now = a_zero ? (count == CNT_MAX) : a_hit;
      ev_a = a_hit & ~a_zero;
    end else begin
      clear_now = p_zero ? (count == CNT_MAX) : p_hit;
      ev_p = clear_now;
      ev_a = a_hit & ~a_zero;
    end
  end

  // Counter

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      count <= CNT_ZERO;
    end else if (enable_rise) begin
      count <= CNT_ZERO;
    end else if (step) begin
      count <= clear_now ? CNT_ZERO : count + CNT_ONE;
    end
  end

  // Flags

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      match_a_flag <= 1'b0;
      match_p_flag <= 1'b0;
    end else begin
      if (bus_wr && wb_adr_i == ADR_FLAGS && wr_byte[FLAG_A_BIT]) begin
        match_a_flag <= 1'b0;
      end
      if (bus_wr && wb_adr_i == ADR_FLAGS && wr_byte[FLAG_P_BIT]) begin
        match_p_flag <= 1'b0;
      end
      if (step && ev_a) begin
        match_a_flag <= 1'b1;
      end
      if (step && ev_p) begin
        match_p_flag <= 1'b1;
      end
    end
  end

  // Compare output level

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cmp_level <= 1'b0;
    end else if (enable_rise) begin
      cmp_level <= ctrl1.init_level;
    end else if (step && ev_a && ctrl1.mode == PTCP_MODE_CMP) begin
      unique case (ctrl1.io)
        PTCP_IO_00: cmp_level <= cmp_level;
        PTCP_IO_01: cmp_level <= 1'b0;
        PTCP_IO_10: cmp_level <= 1'b1;
        PTCP_IO_11: cmp_level <= ~cmp_level;
      endcase
    end
  end

  // PWM waveform

  assign pwm_full = ~p_zero && (cmp_a >= period);
  assign pwm_on   = pwm_full | (count < cmp_a);

  always_comb begin
    unique case (ctrl1.io)
      PTCP_IO_00: pwm_active = 1'b0;
      PTCP_IO_01: pwm_active = 1'b1;
      PTCP_IO_10: pwm_active = ctrl0.enable & pwm_on;
      PTCP_IO_11: pwm_active = ctrl0.enable;
    endcase
  end

  // Pin drive

  always_comb begin
    next_pin = 1'b0;
    next_oe  = 1'b0;
    unique case (ctrl1.mode)
      PTCP_MODE_CMP: begin
        next_pin = cmp_level ^ ctrl1.invert;
        next_oe  = 1'b1;
      end
      PTCP_MODE_PWM: begin
        next_pin = (pwm_active ? ctrl1.init_level : ~ctrl1.init_level)
                   ^ ctrl1.invert;
        next_oe  = 1'b1;
      end
      PTCP_MODE_TMR: begin
        next_pin = 1'b0;
        next_oe  = 1'b0;
      end
      // Capture is not built; counter then behaves as in timer mode
      PTCP_MODE_CAP: begin
        next_pin = 1'b0;
        next_oe  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      timer_pin    <= 1'b0;
      timer_pin_oe <= 1'b0;
    end else begin
      timer_pin    <= next_pin;
      timer_pin_oe <= next_oe;
    end
  end

endmodule // ptcp_timer

/* File: dv/ptcp_timer_monitor.sv */
// Port-level assertion checker for the periodic timer
`timescale 1ns/1ps
module ptcp_mon
  import ptcp_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        timer_pin,
  input wire logic        timer_pin_oe,
  input wire logic        match_a_flag,
  input wire logic        match_p_flag
);
  logic       take;
  logic       wflg;
  logic [7:0] c1;
  logic [2:0] age;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wflg = take && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_FLAGS;
  // Mode shadow, aged so pin checks skip the settling cycles
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      c1  <= 8'h00;
      age <= 3'h0;
    end else if (take && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_CTRL1) begin
      c1  <= wb_dat_i[7:0];
      age <= 3'h0;
    end else if (age != 3'h7) begin
      age <= age + 3'h1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_req;
    take;
  endsequence
  sequence s_held(logic [1:0] m);
    age == 3'h7 && c1[7:6] == m;
  endsequence
  AST_ACK_ONE: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack is not one pulse after a request");
  AST_CNT_PAD: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i == ADR_CNT_HI |-> wb_dat_o[31:2] == 30'h0)
    else $error("counter high byte pad bits not zero");
  AST_CMP_PAD: assert property (wb_ack_o && !wb_we_i &&
    (wb_adr_i == ADR_CMPA_HI || wb_adr_i == ADR_PER_HI) |->
    wb_dat_o[31:2] == 30'h0)
    else $error("compare high byte pad bits not zero");
  AST_A_STICKY: assert property ($fell(match_a_flag) |->
    $past(wflg && wb_dat_i[FLAG_A_BIT]))
    else $error("A flag fell without a clear write");
  AST_P_STICKY: assert property ($fell(match_p_flag) |->
    $past(wflg && wb_dat_i[FLAG_P_BIT]))
    else $error("P flag fell without a clear write");
  AST_NO_P: assert property (s_held(PTCP_MODE_CMP) ##0 c1[0] |->
    !$rose(match_p_flag))
    else $error("P flag raised while clearing on A");
  AST_TMR_OFF: assert property (s_held(PTCP_MODE_TMR) |->
    !timer_pin_oe)
    else $error("pin driven in timer mode");
  AST_CMP_OE: assert property (s_held(PTCP_MODE_CMP) |->
    timer_pin_oe)
    else $error("pin not driven in compare mode");
  AST_PWM_OFF: assert property (s_held(PTCP_MODE_PWM) ##0
    c1[5:4] == 2'b00 |-> timer_pin_oe && timer_pin == (!c1[3] ^ c1[2]))
    else $error("forced inactive PWM level wrong");
endmodule // ptcp_mon
bind ptcp_timer ptcp_mon u_mon (.clk_sys(clk_sys), .nrst(nrst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_pin(timer_pin),
  .timer_pin_oe(timer_pin_oe), .match_a_flag(match_a_flag),
  .match_p_flag(match_p_flag));

/* File: dv/ptcp_partner.sv */
// Far side model: trigger source, sub clock and pin load
`timescale 1ns/1ps
module ptcp_partner (
  input  wire logic clk_sys,
  input  wire logic fire,
  input  wire logic timer_pin,
  input  wire logic timer_pin_oe,
  output logic      trigger_pin,
  output logic      sub_clk_tick,
  output logic      pin_seen
);
  logic [2:0] div = 3'h0;
  initial trigger_pin = 1'b0;
  initial sub_clk_tick = 1'b0;
  // Load has a pull-down, so a released pin reads low
  assign pin_seen = timer_pin_oe ? timer_pin : 1'b0;
  // Sub clock runs free, one pulse in eight
  always @(posedge clk_sys) begin
    div <= div + 3'h1;
    sub_clk_tick <= (div == 3'h7);
  end
  always @(posedge clk_sys) begin
    trigger_pin <= fire;
  end
endmodule // ptcp_partner

/* File: dv/ptcp_timer_tb_top.sv */
// Self-checking bench for the periodic timer
`timescale 1ns/1ps
module ptcp_timer_tb_top
  import ptcp_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        fire = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dw = 32'h0;
  logic [31:0] dr;
  logic        ack, pin, oe, fa, fp, trg, sub, seen;
  logic [15:0] q, v;
  int          mismatches = 0;
  int          n_tests = 0;
  int          h;
  logic [9:0]  ta [5] = '{10'h001, 10'h001, 10'h005, 10'h200, 10'h001};
  logic [9:0]  tp [5] = '{10'h003, 10'h004, 10'h004, 10'h000, 10'h004};
  logic [7:0]  tm [5] = '{8'ha8, 8'hac, 8'ha8, 8'ha8, 8'h88};
  int          tw [5] = '{12, 8, 8, 1024, 8};
  logic [15:0] th [5] = '{16'h4, 16'h6, 16'h8, 16'h200, 16'h0};
  logic [15:0] tf [5] = '{16'h3, 16'h3, 16'h2, 16'h3, 16'h3};
  always #50 clk_sys = ~clk_sys;
  ptcp_timer uut (.clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .sub_clk_tick(sub),
    .trigger_pin(trg), .timer_pin(pin), .timer_pin_oe(oe),
    .match_a_flag(fa), .match_p_flag(fp));
  ptcp_partner pm (.clk_sys(clk_sys), .fire(fire), .timer_pin(pin),
    .timer_pin_oe(oe), .trigger_pin(trg), .sub_clk_tick(sub),
    .pin_seen(seen));
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Classic cycle: hold until ack is sampled, then release for one cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    dw <= {24'h0, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dr[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_sys);
    if (n >= 50) begin
      mismatches++;
      conclude();
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] exp);
    bus(1'b0, a, 8'h00);
    chk(q, exp);
  endtask
  task automatic set10(input logic [7:0] a, input logic [9:0] x);
    bus(1'b1, a, x[7:0]);
    bus(1'b1, a + 8'h04, {6'h0, x[9:8]});
  endtask
  // Mode is only changed with the counter stopped
  task automatic go(input logic [7:0] m, input logic [7:0] c, input int n);
    bus(1'b1, ADR_CTRL0, 8'h00);
    bus(1'b1, ADR_CTRL1, m);
    bus(1'b1, ADR_FLAGS, 8'h03);
    bus(1'b1, ADR_CTRL0, c);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic duty(input int n);
    h = 0;
    repeat (n) begin
      @(posedge clk_sys);
      h += int'(seen === 1'b1);
    end
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    for (int a = 0; a <= 36; a += 4) rc(8'(a), 16'h0);
    bus(1'b1, ADR_CNT_HI, 8'hff);
    set10(ADR_CMPA_LO, 10'h3ff);
    set10(ADR_PER_LO, 10'h2fe);
    rc(ADR_CNT_HI, 16'h0);
    rc(ADR_CMPA_HI, 16'h3);
    rc(ADR_PER_LO, 16'hfe);
    bus(1'b1, ADR_PER_HI, 8'hfe);
    rc(ADR_PER_HI, 16'h2);
    set10(ADR_CMPA_LO, 10'h001);
    set10(ADR_PER_LO, 10'h003);
    go(8'h20, 8'h18, 30);
    chk(16'(seen), 16'h1);
    chk(16'({fp, fa}), 16'h3);
    go(8'h00, 8'h18, 30);
    chk(16'(seen), 16'h0);
    go(8'h30, 8'h18, 20);
    duty(8);
    chk(16'(h), 16'h4);
    go(8'hc0, 8'h18, 30);
    chk(16'({oe, fp, fa}), 16'h3);
    set10(ADR_CMPA_LO, 10'h005);
    set10(ADR_PER_LO, 10'h002);
    go(8'h01, 8'h18, 40);
    rc(ADR_FLAGS, 16'h1);
    bus(1'b1, ADR_CTRL0, 8'h00);
    bus(1'b0, ADR_CNT_LO, 8'h00);
    chk(16'(q <= 16'h5), 16'h1);
    bus(1'b1, ADR_FLAGS, 8'h02);
    rc(ADR_FLAGS, 16'h1);
    bus(1'b1, ADR_FLAGS, 8'h01);
    rc(ADR_FLAGS, 16'h0);
    set10(ADR_CMPA_LO, 10'h000);
    go(8'h01, 8'h18, 1100);
    rc(ADR_FLAGS, 16'h0);
    for (int i = 0; i < 5; i++) begin
      set10(ADR_CMPA_LO, ta[i]);
      set10(ADR_PER_LO, tp[i]);
      go(tm[i], 8'h18, 20);
      duty(tw[i]);
      chk(16'(h), th[i]);
      chk(16'({fp, fa}), tf[i]);
    end
    set10(ADR_PER_LO, 10'h000);
    go(8'h00, 8'h08, 40);
    bus(1'b1, ADR_CTRL0, 8'h88);
    bus(1'b0, ADR_CNT_LO, 8'h00);
    v = q;
    repeat (20) @(posedge clk_sys);
    rc(ADR_CNT_LO, v);
    bus(1'b1, ADR_CTRL0, 8'h08);
    repeat (20) @(posedge clk_sys);
    bus(1'b0, ADR_CNT_LO, 8'h00);
    chk(16'(q > v), 16'h1);
    // Trigger rising edge as counter clock: one step per pulse
    go(8'hc0, 8'h68, 4);
    repeat (5) begin
      fire <= 1'b1;
      @(posedge clk_sys);
      fire <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
    rc(ADR_CNT_LO, 16'h5);
    // Free running dividers, so allow one step of phase slack
    go(8'hc0, 8'h48, 80);
    bus(1'b0, ADR_CNT_LO, 8'h00);
    chk(16'(q >= 16'h9 && q <= 16'hc), 16'h1);
    go(8'hc0, 8'h38, 256);
    bus(1'b0, ADR_CNT_LO, 8'h00);
    chk(16'(q >= 16'h3 && q <= 16'h5), 16'h1);
    set10(ADR_CMPA_LO, 10'h014);
    go(8'h18, 8'h18, 6);
    chk(16'(seen), 16'h1);
    repeat (30) @(posedge clk_sys);
    chk(16'(seen), 16'h0);
    go(8'h1c, 8'h18, 6);
    chk(16'(seen), 16'h0);
    go(8'hb8, 8'h10, 4);
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk(16'(seen), 16'h1);
    repeat (40) @(posedge clk_sys);
    chk(16'({seen, fa}), 16'h1);
    rc(ADR_CTRL0, 16'h10);
    bus(1'b0, ADR_CNT_LO, 8'h00);
    chk(16'(q >= 16'h14), 16'h1);
    v = q;
    repeat (10) @(posedge clk_sys);
    rc(ADR_CNT_LO, v);
    conclude();
  end
endmodule // ptcp_timer_tb_top
